// ### rtl/cprc_contact_ctrl.sv
// Contact input decoder, program run control and contact output top level
//
// How it works
// RULE1: four contacts weigh 1,2,4,8 into pattern
// RULE2: second only gives 2, first+second give 3
// RULE3: eighth contact adds sixteen to pattern
// RULE4: pattern taken only in reset mode
// RULE5: fifth contact rising starts program run
// RULE6: sixth contact rising stops program run
// RULE7: stopped operation drives active group preset
// RULE8: stop preset overrides manual output value
// RULE9: seventh contact switches source when method 2
// RULE10: eight groups held, one active
// RULE11: setting picks current, pulse or relay output
// RULE12: PV events to contact outputs 1, 2
// RULE13: instrument alarm to contact output 3
// RULE14: time events 1-4 to outputs 4-7
// RULE15: retransmission 1 source PV, setpoint or MV
// RULE16: retransmission 2 only with relay main output
// RULE17: loop supply when type 4, no retransmission
// RULE18: seventh contact off input 1, on input 2
// RULE19: contacts synchronised, rising edges give pulses
`timescale 1ns/1ns
`default_nettype none
module cprc_contact_ctrl
	import cprc_pkg::*;
#(
	parameter int GROUPS = 8,
	parameter int VW = 16
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire cprc_contact_t contactIn,
	input wire cprc_event_t eventIn,
	input wire logic autoSourceSel,
	input wire logic [VW-1:0] pvInputA,
	input wire logic [VW-1:0] pvInputB,
	input wire logic [VW-1:0] programSetpoint,
	input wire logic [VW-1:0] pidOutput,
	output logic [6:0] contactOut,
	output logic [4:0] patternNum,
	output logic programRunning,
	output logic pvSourceSel,
	output logic [VW-1:0] pvValue,
	output logic [2:0] activeGroup,
	output logic [VW-1:0] ctrlOutValue,
	output logic [2:0] ctrlOutKind,
	output cprc_route_t retransOut
);
	initial begin
		if (GROUPS != 8 || VW != 16) begin
			$error("cprc_contact_ctrl supports GROUPS=8 and VW=16 only");
		end
	end

	// Register state
	logic [31:0] config_q; // Method, output types, active group
	logic [31:0] manual_q; // Manual value and enable
	logic [VW-1:0] preset_q [GROUPS]; // Preset output per group, see RULE10
	logic waitReq_q; // Avalon wait, one wait cycle per access
	logic [31:0] rdData_q; // Captured read data
	cprc_mode_t mode_q; // Reset or run mode
	logic [4:0] pattern_q; // Selected pattern number
	logic [6:0] contactOut_q;
	logic pvSel_q;
	logic [VW-1:0] pvValue_q;
	logic [VW-1:0] ctrlOut_q;
	logic [2:0] outKind_q;
	cprc_route_t route_q;

	// Byte-lane merge used for every writable word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return res;
	endfunction

	// Synchronised contacts and their rising edges
	wire logic [7:0] contactLvl;
	wire logic [7:0] contactRise;
	cprc_contact_sync #(.WIDTH(8)) u_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.rawIn(contactIn),
		.level(contactLvl),
		.rise(contactRise)
	);
	cprc_contact_t lvl;
	cprc_contact_t rise;
	assign lvl = contactLvl;
	assign rise = contactRise;

	// Configuration fields
	wire logic [1:0] switchMethodSel = config_q[CPRC_CFG_SWM_LSB +: 2];
	wire logic [1:0] mainOutputTypeSel = config_q[CPRC_CFG_OTY_LSB +: 2];
	wire logic [2:0] retransATypeSel = config_q[CPRC_CFG_RTA_LSB +: 3];
	wire logic [2:0] retransBTypeSel = config_q[CPRC_CFG_RTB_LSB +: 3];
	wire logic [2:0] groupSel = config_q[CPRC_CFG_GRP_LSB +: 3];
	wire logic manualEn = manual_q[CPRC_MAN_EN_BIT];
	wire logic [VW-1:0] manualValue = manual_q[VW-1:0];

	// Bus decode; a request is taken in its first cycle
	wire logic busReq = (avs_read || avs_write) && waitReq_q;
	wire logic busDone = (avs_read || avs_write) && !waitReq_q;
	wire logic hitConfig = (avs_address == CPRC_OFS_CONFIG);
	wire logic hitManual = (avs_address == CPRC_OFS_MANUAL);
	wire logic hitStatus = (avs_address == CPRC_OFS_STATUS);
	wire logic hitPreset = (avs_address >= CPRC_OFS_PRESET) &&
		(avs_address <= CPRC_OFS_PRESET_END) && (avs_address[1:0] == 2'b00);
	wire logic [2:0] presetIdx = avs_address[4:2];
	wire logic [7:0] statusWord = {1'b0, pvSel_q, (mode_q == CPRC_MODE_RUN), pattern_q};

	// Read mux; unmapped addresses read zero
	wire logic [31:0] rdMux = hitConfig ? config_q :
		hitManual ? manual_q :
		hitStatus ? {17'h0_0000, contactOut_q, statusWord} :
		hitPreset ? {16'h0000, preset_q[presetIdx]} : 32'h0000_0000;

	// Pattern decode: binary weights plus upper bank offset
	wire logic patternValid = (lvl.patternBits != 4'h0); // see RULE1
	wire logic [4:0] patternDecoded = {1'b0, lvl.patternBits} +
		(lvl.upperBank ? CPRC_BANK_OFFSET : 5'h00); // see RULE1, see RULE2, see RULE3

	// Run control; a stop edge beats a start edge in the same cycle
	wire logic startReq = rise.run && !rise.halt; // see RULE5
	wire logic stopReq = rise.halt; // see RULE6
	cprc_mode_t modeNext;
	assign modeNext = stopReq ? CPRC_MODE_RESET :
		(startReq ? CPRC_MODE_RUN : mode_q);

	// Source selection: contact only under method 2, else the range logic
	wire logic srcSel_d = (switchMethodSel == CPRC_SWM_CONTACT) ?
		lvl.sourceSwitch : autoSourceSel; // see RULE9, see RULE18
	wire logic [VW-1:0] pvValue_d = srcSel_d ? pvInputB : pvInputA; // see RULE18

	// Control output: preset when stopped, ahead of manual and PID
	wire logic [VW-1:0] ctrlOut_d = (mode_q == CPRC_MODE_RESET) ? preset_q[groupSel] :
		(manualEn ? manualValue : pidOutput); // see RULE7, see RULE8, see RULE10

	// One-hot output kind: bit0 current, bit1 pulse, bit2 relay
	wire logic [2:0] outKind_d = {mainOutputTypeSel == CPRC_OTY_RELAY,
		mainOutputTypeSel == CPRC_OTY_PULSE,
		mainOutputTypeSel == CPRC_OTY_CURRENT}; // see RULE11

	// Event routing in ascending contact order
	wire logic [6:0] contactOut_d = {eventIn.timeEvent, eventIn.alarmA,
		eventIn.pvEvent[1], eventIn.pvEvent[0]}; // see RULE12, see RULE13, see RULE14

	// Retransmission selection works on the registered selected PV and output
	cprc_route_t route_d;
	cprc_out_route u_route (
		.mainType(mainOutputTypeSel),
		.retransAType(retransATypeSel),
		.retransBType(retransBTypeSel),
		.pvValue(pvValue_q),
		.setpoint(programSetpoint),
		.ctrlValue(ctrlOut_q),
		.route(route_d)
	);

	// Avalon slave: one wait state, then readdata and write commit together
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			waitReq_q <= 1'b1;
			rdData_q <= 32'h0000_0000;
		end else begin
			waitReq_q <= !busReq;
			if (busReq && avs_read) begin
				rdData_q <= rdMux;
			end
		end
	end

	// Writable registers; commit at the edge where waitrequest is low
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			config_q <= CPRC_CFG_RESET;
			manual_q <= CPRC_MAN_RESET;
		end else if (busDone && avs_write) begin
			if (hitConfig) begin
				config_q <= merge(config_q, avs_writedata, avs_byteenable);
			end
			if (hitManual) begin
				manual_q <= merge(manual_q, avs_writedata, avs_byteenable);
			end
		end
	end

	// Preset table, one word per group
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int g = 0; g < GROUPS; g++) begin
				preset_q[g] <= CPRC_PRESET_RESET;
			end
		end else if (busDone && avs_write && hitPreset) begin
			preset_q[presetIdx] <= VW'(merge({16'h0000, preset_q[presetIdx]},
				avs_writedata, avs_byteenable));
		end
	end

	// Mode and pattern; pattern only follows contacts in reset mode
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_q <= CPRC_MODE_RESET;
			pattern_q <= 5'h01;
		end else begin
			mode_q <= modeNext; // see RULE5, see RULE6
			if (mode_q == CPRC_MODE_RESET && patternValid) begin
				pattern_q <= patternDecoded; // see RULE4
			end
		end
	end

	// Output flops so every port comes from a register
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			contactOut_q <= 7'h00;
			pvSel_q <= 1'b0;
			pvValue_q <= '0;
			ctrlOut_q <= '0;
			outKind_q <= 3'h1;
			route_q <= '0;
		end else begin
			contactOut_q <= contactOut_d;
			pvSel_q <= srcSel_d;
			pvValue_q <= pvValue_d;
			ctrlOut_q <= ctrlOut_d;
			outKind_q <= outKind_d;
			route_q <= route_d;
		end
	end

	assign avs_waitrequest = waitReq_q;
	assign avs_readdata = rdData_q;
	assign contactOut = contactOut_q;
	assign patternNum = pattern_q;
	assign programRunning = (mode_q == CPRC_MODE_RUN);
	assign pvSourceSel = pvSel_q;
	assign pvValue = pvValue_q;
	assign activeGroup = groupSel;
	assign ctrlOutValue = ctrlOut_q;
	assign ctrlOutKind = outKind_q;
	assign retransOut = route_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// A run contact going on in reset mode, with no stop edge
	sequence runEdgeSeq;
		!lvl.run && mode_q == CPRC_MODE_RESET ##1 lvl.run && !rise.halt;
	endsequence

	start_on_edge_a: assert property (runEdgeSeq |=> mode_q == CPRC_MODE_RUN) // see RULE5
		else $error("run edge did not start program");
	stop_on_edge_a: assert property (rise.halt |=> mode_q == CPRC_MODE_RESET) // see RULE6
		else $error("halt edge did not stop program");
	pattern_frozen_a: assert property (mode_q == CPRC_MODE_RUN |=> $stable(pattern_q)) // see RULE4
		else $error("pattern changed while running");
	pattern_decode_a: assert property (mode_q == CPRC_MODE_RESET && patternValid |=> // see RULE3
		pattern_q == {1'b0, $past(lvl.patternBits)} + ($past(lvl.upperBank) ? 5'h10 : 5'h00))
		else $error("pattern decode wrong");
	preset_stop_a: assert property (mode_q == CPRC_MODE_RESET |=>
		ctrlOut_q == $past(preset_q[groupSel])) // see RULE7
		else $error("stopped output is not the preset");
	contact_order_a: assert property (1'b1 |=> contactOut_q[3] == $past(eventIn.timeEvent[0])
		&& contactOut_q[2] == $past(eventIn.alarmA)) // see RULE14
		else $error("contact output order wrong");
	source_method_a: assert property (switchMethodSel != CPRC_SWM_CONTACT |=>
		pvSel_q == $past(autoSourceSel)) // see RULE9
		else $error("contact switched source outside method 2");
	retrans_b_a: assert property (route_q.retransBEn |-> // see RULE16
		$past(mainOutputTypeSel) == CPRC_OTY_RELAY)
		else $error("second retransmission without relay output");
	loop_excl_a: assert property (route_q.retransAEn |-> // see RULE17
		$past(retransATypeSel) != CPRC_RT_LOOP)
		else $error("retransmission on loop supply terminal");
	bus_wait_a: assert property (busReq |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest not one cycle");
	// Both PV event bits land on the two lowest contact outputs
	pv_event_a: assert property (1'b1 |=> // see RULE12
		contactOut_q[1:0] == $past(eventIn.pvEvent))
		else $error("PV event outputs out of place");
	// Selected input reaches the PV register one edge later
	source_pick_a: assert property (1'b1 |=> // see RULE18
		pvValue_q == ($past(srcSel_d) ? $past(pvInputB) : $past(pvInputA)))
		else $error("PV taken from the wrong input");
	// Setpoint retransmission carries the live program setpoint
	retrans_sp_a: assert property ($past(retransATypeSel) == CPRC_RT_SP |-> // see RULE15
		route_q.retransAValue == $past(programSetpoint))
		else $error("retransmission does not carry the setpoint");
endmodule // cprc_contact_ctrl
`default_nettype wire

// ### rtl/cprc_pkg.sv
// Shared constants, register map and carrier types for the contact I/O block
package cprc_pkg;

	// Register byte offsets on the Avalon slave
	localparam logic [7:0] CPRC_OFS_CONFIG = 8'h00;
	localparam logic [7:0] CPRC_OFS_MANUAL = 8'h04;
	localparam logic [7:0] CPRC_OFS_STATUS = 8'h08;
	localparam logic [7:0] CPRC_OFS_PRESET = 8'h20;
	localparam logic [7:0] CPRC_OFS_PRESET_END = 8'h3C;

	// Configuration register fields
	localparam int CPRC_CFG_SWM_LSB = 0;
	localparam int CPRC_CFG_OTY_LSB = 2;
	localparam int CPRC_CFG_RTA_LSB = 4;
	localparam int CPRC_CFG_RTB_LSB = 8;
	localparam int CPRC_CFG_GRP_LSB = 12;
	localparam logic [31:0] CPRC_CFG_RESET = 32'h0000_0000;

	// Manual register fields
	localparam int CPRC_MAN_EN_BIT = 16;
	localparam logic [31:0] CPRC_MAN_RESET = 32'h0000_0000;
	localparam logic [15:0] CPRC_PRESET_RESET = 16'h0000;

	// Setting encodings
	localparam logic [1:0] CPRC_SWM_CONTACT = 2'h2;
	localparam logic [1:0] CPRC_OTY_CURRENT = 2'h0;
	localparam logic [1:0] CPRC_OTY_PULSE = 2'h1;
	localparam logic [1:0] CPRC_OTY_RELAY = 2'h2;
	localparam logic [2:0] CPRC_RT_PV = 3'h1;
	localparam logic [2:0] CPRC_RT_SP = 3'h2;
	localparam logic [2:0] CPRC_RT_MV = 3'h3;
	localparam logic [2:0] CPRC_RT_LOOP = 3'h4;
	localparam logic [4:0] CPRC_BANK_OFFSET = 5'h10;

	// Program operation modes
	typedef enum logic {CPRC_MODE_RESET, CPRC_MODE_RUN} cprc_mode_t;

	// Eight contact inputs as one word
	typedef struct packed {
		logic upperBank;
		logic sourceSwitch;
		logic halt;
		logic run;
		logic [3:0] patternBits;
	} cprc_contact_t;

	// Internal events routed to contact outputs
	typedef struct packed {
		logic [3:0] timeEvent;
		logic alarmA;
		logic [1:0] pvEvent;
	} cprc_event_t;

	// Retransmission and loop supply selection result
	typedef struct packed {
		logic retransAEn;
		logic [15:0] retransAValue;
		logic retransBEn;
		logic [15:0] retransBValue;
		logic loopSupplyEn;
	} cprc_route_t;

endpackage

// ### rtl/cprc_contact_sync.sv
// Two-stage synchroniser with rising edge detect for the contact inputs
`timescale 1ns/1ns
`default_nettype none
module cprc_contact_sync #(
	parameter int WIDTH = 8
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] rawIn,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise
);
	logic [WIDTH-1:0] meta_q; // First stage, read only by the second
	logic [WIDTH-1:0] sync_q; // Second stage, safe to use
	logic [WIDTH-1:0] prev_q; // Previous synchronised sample

	initial begin
		if (WIDTH < 1) begin
			$error("cprc_contact_sync needs WIDTH of at least 1");
		end
	end

	// Shift chain; contacts bounce, so upstream debounce is assumed
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= rawIn;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// One-cycle pulse on an off-to-on change of two samples
	assign level = sync_q;
	assign rise = sync_q & ~prev_q; // see RULE19
endmodule // cprc_contact_sync
`default_nettype wire

// ### rtl/cprc_out_route.sv
// Retransmission source and loop supply selection for the shared terminals
`timescale 1ns/1ns
`default_nettype none
module cprc_out_route
	import cprc_pkg::*;
(
	input wire logic [1:0] mainType,
	input wire logic [2:0] retransAType,
	input wire logic [2:0] retransBType,
	input wire logic [15:0] pvValue,
	input wire logic [15:0] setpoint,
	input wire logic [15:0] ctrlValue,
	output cprc_route_t route
);
	// Picks a retransmission source; unknown codes give zero
	function automatic logic [15:0] pick(input logic [2:0] typ, input logic [15:0] pv,
			input logic [15:0] sp, input logic [15:0] mv);
		logic [15:0] res;
		res = 16'h0000;
		if (typ == CPRC_RT_PV) begin
			res = pv;
		end else if (typ == CPRC_RT_SP) begin
			res = sp;
		end else if (typ == CPRC_RT_MV) begin
			res = mv;
		end
		return res;
	endfunction

	// Source is live only for the three value codes
	function automatic logic isSource(input logic [2:0] typ);
		return (typ == CPRC_RT_PV) || (typ == CPRC_RT_SP) || (typ == CPRC_RT_MV);
	endfunction

	wire logic mainIsRelay = (mainType == CPRC_OTY_RELAY);
	wire logic loopA = (retransAType == CPRC_RT_LOOP);
	wire logic loopB = (retransBType == CPRC_RT_LOOP);

	// Output 1 takes any of the three sources
	assign route.retransAEn = isSource(retransAType); // see RULE15
	assign route.retransAValue = pick(retransAType, pvValue, setpoint, ctrlValue); // see RULE15
	// Output 2 shares the main terminal, so only a relay main output frees it
	assign route.retransBEn = mainIsRelay && isSource(retransBType); // see RULE16
	assign route.retransBValue = pick(retransBType, pvValue, setpoint, ctrlValue);
	// Loop supply takes the terminal instead of retransmission
	assign route.loopSupplyEn = loopA || loopB; // see RULE17
endmodule // cprc_out_route
`default_nettype wire

// ### tb/cprc_switch_model.sv
// Behavioural model of the external switches and relays that drive the contacts
`timescale 1ns/1ns
`default_nettype none
module cprc_switch_model
	import cprc_pkg::*;
(
	input wire logic core_clk,
	input wire cprc_contact_t wanted,
	output cprc_contact_t contactIn
);
	// Switches settle on a clock edge; the device still sees them as asynchronous levels
	// Single driver; unknown only until the first edge, while reset still holds
	always @(posedge core_clk) begin
		contactIn <= wanted;
	end
endmodule // cprc_switch_model
`default_nettype wire

// ### tb/contact_io_pattern_run_control_tb.sv
// Self-checking bench for the contact decoder and run control block
`timescale 1ns/1ns
`default_nettype none
module contact_io_pattern_run_control_tb;
	import cprc_pkg::*;
	logic core_clk = 1'b0; // 125 MHz system clock
	logic reset_n = 1'b0; // Active low reset
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF; // Whole words only
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	cprc_contact_t wanted = '0; // Switch positions asked of the model
	cprc_contact_t contactIn;
	cprc_event_t eventIn = '0;
	logic autoSourceSel = 1'b0;
	logic [15:0] pvInputA = 16'h0, pvInputB = 16'h0, programSetpoint = 16'h0, pidOutput = 16'h0;
	logic [6:0] contactOut;
	logic [4:0] patternNum;
	logic programRunning, pvSourceSel;
	logic [15:0] pvValue, ctrlOutValue;
	logic [2:0] activeGroup, ctrlOutKind;
	cprc_route_t retransOut;
	int seed = 32'h5dc14fbf; // Fixed so a failing run can be repeated
	int failCount = 0;
	int checksDone = 0;
	logic [15:0] presets [8]; // Preset value written per group
	logic [31:0] rd;
	logic [4:0] expPat;
	logic [3:0] code;
	logic bank;
	logic [15:0] mv;

	// Free running clock, 8 ns period
	always #4 core_clk = ~core_clk;

	cprc_switch_model cprc_switch_model_i (.core_clk(core_clk), .wanted(wanted), .contactIn(contactIn));

	cprc_contact_ctrl cprc_contact_ctrl_i (
		.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .contactIn(contactIn), .eventIn(eventIn),
		.autoSourceSel(autoSourceSel), .pvInputA(pvInputA), .pvInputB(pvInputB),
		.programSetpoint(programSetpoint), .pidOutput(pidOutput), .contactOut(contactOut),
		.patternNum(patternNum), .programRunning(programRunning), .pvSourceSel(pvSourceSel),
		.pvValue(pvValue), .activeGroup(activeGroup), .ctrlOutValue(ctrlOutValue),
		.ctrlOutKind(ctrlOutKind), .retransOut(retransOut)
	);

	// Verdict and end of run, the only exit
	task automatic endSim();
		if (failCount == 0 && checksDone > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One comparison, reported at once when it misses
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			failCount++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One Avalon transfer; request held until waitrequest is sampled low
	task automatic busXfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		@(posedge core_clk);
		avs_address <= adr;
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata; // Taken at the edge that ends the wait
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// A slave that never answers ends the run rather than hanging it
		if (avs_waitrequest !== 1'b0) begin
			failCount++;
			endSim();
		end
	endtask

	// Configuration word from its fields
	function automatic logic [31:0] cfgWord(input logic [1:0] swm, input logic [1:0] oty,
		input logic [2:0] rta, input logic [2:0] rtb, input logic [2:0] grp);
		return (32'(swm) << CPRC_CFG_SWM_LSB) | (32'(oty) << CPRC_CFG_OTY_LSB) |
			(32'(rta) << CPRC_CFG_RTA_LSB) | (32'(rtb) << CPRC_CFG_RTB_LSB) |
			(32'(grp) << CPRC_CFG_GRP_LSB);
	endfunction

	// Pattern expected from the four weighted contacts and the upper bank contact
	function automatic logic [4:0] patOf(input logic [3:0] c, input logic b);
		return {1'b0, c} + (b ? 5'h10 : 5'h00);
	endfunction

	// Move the switches, then give sync, edge stage and mode register time to land
	task automatic setContacts(input cprc_contact_t v);
		@(posedge core_clk);
		wanted <= v;
		repeat (6) @(posedge core_clk);
	endtask

	initial begin
		// Reset held for eight cycles, released just after an edge
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		check(patternNum, 32'h1);
		check(programRunning, 32'h0);
		check(ctrlOutKind, 32'h1);
		// Reset values, then a write and read-back of zero at an unmapped place
		busXfer(1'b0, CPRC_OFS_CONFIG, 32'h0);
		check(rd, CPRC_CFG_RESET);
		busXfer(1'b0, CPRC_OFS_MANUAL, 32'h0);
		check(rd, CPRC_MAN_RESET);
		busXfer(1'b1, 8'h10, 32'hFFFF_FFFF);
		busXfer(1'b0, 8'h10, 32'h0);
		check(rd, 32'h0);
		// Presets per group; upper half is not stored
		for (int g = 0; g < 8; g++) begin
			busXfer(1'b0, CPRC_OFS_PRESET + 8'(4 * g), 32'h0);
			check(rd, 32'(CPRC_PRESET_RESET));
			presets[g] = 16'($random(seed));
			busXfer(1'b1, CPRC_OFS_PRESET + 8'(4 * g), {16'hA5A5, presets[g]});
			busXfer(1'b0, CPRC_OFS_PRESET + 8'(4 * g), 32'h0);
			check(rd, {16'h0, presets[g]});
		end
		// Every group in turn; stopped output is that group's preset
		for (int g = 0; g < 8; g++) begin
			busXfer(1'b1, CPRC_OFS_CONFIG, cfgWord(2'h0, 2'h0, 3'h0, 3'h0, 3'(g)));
			repeat (3) @(posedge core_clk);
			check(activeGroup, 32'(g));
			check(ctrlOutValue, 32'(presets[g]));
		end
		// Each main output type gives its own one-hot kind
		for (int t = 0; t < 3; t++) begin
			busXfer(1'b1, CPRC_OFS_CONFIG, cfgWord(2'h0, 2'(t), 3'h0, 3'h0, 3'h5));
			repeat (3) @(posedge core_clk);
			check(ctrlOutKind, 32'(1 << t));
		end
		// Events appear on their fixed contact outputs
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk);
			eventIn <= (i == 0) ? 7'h55 : 7'($random(seed));
			repeat (3) @(posedge core_clk);
			check(contactOut[1:0], 32'(eventIn.pvEvent));
			check(contactOut[2], 32'(eventIn.alarmA));
			check(contactOut[6:3], 32'(eventIn.timeEvent));
		end
		// Pattern codes in reset mode, pattern 2 and 3 first
		for (int i = 0; i < 12; i++) begin
			code = (i == 0) ? 4'h2 : (i == 1) ? 4'h3 : 4'(({$random(seed)} % 15) + 1);
			bank = (i < 2) ? 1'b0 : 1'($random(seed));
			setContacts('{upperBank: bank, sourceSwitch: 1'b0, halt: 1'b0, run: 1'b0,
				patternBits: code});
			check(patternNum, 32'(patOf(code, bank)));
		end
		expPat = patOf(code, bank);
		// Source choice: contact only under method 2, otherwise the automatic one
		pvInputA <= 16'($random(seed));
		pvInputB <= 16'($random(seed));
		programSetpoint <= 16'($random(seed));
		pidOutput <= 16'($random(seed));
		busXfer(1'b1, CPRC_OFS_CONFIG, cfgWord(CPRC_SWM_CONTACT, 2'h0, 3'h0, 3'h0, 3'h5));
		for (int s = 0; s < 2; s++) begin
			setContacts('{upperBank: bank, sourceSwitch: 1'(s), halt: 1'b0, run: 1'b0,
				patternBits: code});
			check(pvSourceSel, 32'(s));
			check(pvValue, 32'(s ? pvInputB : pvInputA));
		end
		busXfer(1'b1, CPRC_OFS_CONFIG, cfgWord(2'h0, 2'h0, 3'h0, 3'h0, 3'h5));
		repeat (3) @(posedge core_clk);
		check(pvSourceSel, 32'h0);
		// Automatic choice must reach the source select outside method 2
		autoSourceSel <= 1'b1;
		repeat (3) @(posedge core_clk);
		check(pvSourceSel, 32'h1);
		check(pvValue, 32'(pvInputB));
		autoSourceSel <= 1'b0;
		// Start, manual, then a pattern change that must be ignored while running, then stop
		setContacts('{upperBank: bank, sourceSwitch: 1'b0, halt: 1'b0, run: 1'b1,
			patternBits: code});
		check(programRunning, 32'h1);
		check(ctrlOutValue, 32'(pidOutput));
		mv = 16'($random(seed));
		busXfer(1'b1, CPRC_OFS_MANUAL, (32'h1 << CPRC_MAN_EN_BIT) | 32'(mv));
		repeat (3) @(posedge core_clk);
		check(ctrlOutValue, 32'(mv));
		code = (code == 4'hF) ? 4'h1 : code + 4'h1;
		setContacts('{upperBank: bank, sourceSwitch: 1'b0, halt: 1'b0, run: 1'b1,
			patternBits: code});
		check(patternNum, 32'(expPat));
		check(programRunning, 32'h1);
		setContacts('{upperBank: bank, sourceSwitch: 1'b0, halt: 1'b1, run: 1'b1,
			patternBits: code});
		check(programRunning, 32'h0);
		check(ctrlOutValue, 32'(presets[5]));
		check(patternNum, 32'(patOf(code, bank)));
		// Status is read-only and mirrors pattern, mode, source and contact outputs
		busXfer(1'b1, CPRC_OFS_STATUS, 32'hFFFF_FFFF);
		busXfer(1'b0, CPRC_OFS_STATUS, 32'h0);
		check(rd, {17'h0_0000, 7'(eventIn), 3'h0, patOf(code, bank)});
		setContacts('{upperBank: bank, sourceSwitch: 1'b0, halt: 1'b0, run: 1'b0,
			patternBits: code});
		check(programRunning, 32'h0);
		// Retransmission sources with a relay main output
		for (int t = 1; t < 4; t++) begin
			busXfer(1'b1, CPRC_OFS_CONFIG, cfgWord(2'h0, CPRC_OTY_RELAY, 3'(t), 3'(t), 3'h5));
			repeat (4) @(posedge core_clk);
			check(retransOut.retransAEn, 32'h1);
			check(retransOut.retransAValue, 32'(t == 1 ? pvInputA : t == 2 ? programSetpoint :
				presets[5]));
			check(retransOut.retransBEn, 32'h1);
			check(retransOut.retransBValue, 32'(t == 1 ? pvInputA : t == 2 ? programSetpoint :
				presets[5]));
			check(retransOut.loopSupplyEn, 32'h0);
		end
		// Second channel refused without relay; loop supply takes the terminal
		busXfer(1'b1, CPRC_OFS_CONFIG, cfgWord(2'h0, CPRC_OTY_CURRENT, CPRC_RT_LOOP, CPRC_RT_PV,
			3'h5));
		repeat (4) @(posedge core_clk);
		check(retransOut.retransBEn, 32'h0);
		check(retransOut.loopSupplyEn, 32'h1);
		check(retransOut.retransAEn, 32'h0);
		endSim();
	end
endmodule // contact_io_pattern_run_control_tb
`default_nettype wire
